//--- verilog/dmx_exec.v
/*
 decode and execute for copy, bank load, literal load, store and
 literal multiply. assumes instr is valid at q1 and stays for the cycle,
 mem_rdata valid in the same clock as mem_rd_en during q2.
*/
`timescale 1ns/1ps
`include "dmx_defs.vh"
module dmx_exec (
    // clock and reset
    input  wire        core_clk,
    input  wire        sys_rst,
    // fetch side
    input  wire [15:0] instr,
    input  wire        ext_set_en,
    input  wire [7:0]  index_base_hi,
    input  wire [11:0] index_base,
    // data memory
    input  wire [7:0]  mem_rdata,
    output reg  [11:0] mem_addr_r,
    output reg  [7:0]  mem_wdata_r,
    output reg         mem_rd_en_r,
    output reg         mem_wr_en_r,
    // core registers
    output reg  [7:0]  work_r,
    output reg  [7:0]  bank_select_register_r,
    output reg  [7:0]  product_high_byte_r,
    output reg  [7:0]  product_low_byte_r,
    output reg  [1:0]  phase_out_r,
    output reg         copy_second_r
);
    // ======================================================
    // phase
    wire [1:0] phase;
    dmx_phase_gen u_phase (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .phase_r  (phase)
    );
    // ======================================================
    // decode
    wire is_copy1 = instr[15:12] == `DMX_OP_COPY_SRC;
    wire is_copy2 = instr[15:12] == `DMX_OP_COPY_DST;
    wire is_bank  = instr[15:8]  == `DMX_OP_BANK;
    wire is_litw  = instr[15:8]  == `DMX_OP_LIT_W;
    wire is_mul   = instr[15:8]  == `DMX_OP_MUL;
    wire is_store = instr[15:9]  == `DMX_OP_STORE;
    wire       acc_bit = instr[8];
    wire [7:0] fadr    = instr[7:0];
    // ======================================================
    // store address: banked, access or indexed
    reg [11:0] store_addr;
    always @* begin
        if (acc_bit) begin
            store_addr = {bank_select_register_r[3:0], fadr};
        end else if (ext_set_en && fadr <= `DMX_IDX_LIMIT) begin
            store_addr = index_base + {4'h0, fadr};
        end else if (fadr < `DMX_ACC_SPLIT) begin
            store_addr = {4'h0, fadr};
        end else begin
            store_addr = {`DMX_ACC_HI_BANK, fadr};
        end
    end
    wire [15:0] product = work_r * instr[7:0];
    // ======================================================
    // copy state and source byte latch
    reg [7:0] copy_byte_r;
    // w is held here, so map its address to it both ways
    wire src_is_w  = mem_addr_r == `DMX_W_ADDR;
    wire dst_is_w  = instr[11:0] == `DMX_W_ADDR;
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_addr_r             <= `DMX_RST_ADDR;
            mem_wdata_r            <= `DMX_RST_BYTE;
            mem_rd_en_r            <= 1'b0;
            mem_wr_en_r            <= 1'b0;
            work_r                 <= `DMX_RST_BYTE;
            bank_select_register_r <= `DMX_RST_BYTE;
            product_high_byte_r    <= `DMX_RST_BYTE;
            product_low_byte_r     <= `DMX_RST_BYTE;
            copy_byte_r            <= `DMX_RST_BYTE;
            copy_second_r          <= 1'b0;
            phase_out_r            <= `DMX_Q1;
        end else begin
            phase_out_r <= phase;
            mem_rd_en_r <= 1'b0;
            mem_wr_en_r <= 1'b0;
            // read strobe one clock ahead so data lands in q2
            if (phase == `DMX_Q1 && is_copy1 && !copy_second_r) begin
                mem_addr_r  <= instr[11:0];
                mem_rd_en_r <= !(instr[11:0] == `DMX_W_ADDR);
            end
            if (phase == `DMX_Q2 && is_copy1 && !copy_second_r) begin
                copy_byte_r <= src_is_w ? work_r : mem_rdata;
            end
            if (phase == `DMX_Q4) begin
                copy_second_r <= 1'b0;
                if (copy_second_r && is_copy2) begin
                    // no dummy read of the destination
                    if (dst_is_w) begin
                        work_r <= copy_byte_r;
                    end else begin
                        mem_addr_r  <= instr[11:0];
                        mem_wdata_r <= copy_byte_r;
                        mem_wr_en_r <= 1'b1;
                    end
                end else if (is_copy1) begin
                    copy_second_r <= 1'b1;
                end else if (is_bank) begin
                    bank_select_register_r <=
                        instr[7:0] & `DMX_BANK_MASK;
                end else if (is_litw) begin
                    work_r <= instr[7:0];
                end else if (is_store) begin
                    mem_addr_r  <= store_addr;
                    mem_wdata_r <= work_r;
                    mem_wr_en_r <= 1'b1;
                end else if (is_mul) begin
                    // no flag outputs exist; nothing else moves
                    product_high_byte_r <= product[15:8];
                    product_low_byte_r  <= product[7:0];
                end
            end
        end
    end
endmodule

//--- inc/dmx_defs.vh
/*
 constants for the data-move and multiply executor.
 assumes a 16-bit instruction word and 12-bit data addresses.
*/
`ifndef DMX_DEFS_VH
`define DMX_DEFS_VH
// ==========================================================
// opcode fields
`define DMX_OP_COPY_SRC   4'hC
`define DMX_OP_COPY_DST   4'hF
`define DMX_OP_BANK       8'h01
`define DMX_OP_LIT_W      8'h0E
`define DMX_OP_MUL        8'h0D
`define DMX_OP_STORE      7'h37
// ==========================================================
// addressing
`define DMX_IDX_LIMIT     8'h5F
`define DMX_ACC_SPLIT     8'h60
`define DMX_ACC_HI_BANK   4'hF
`define DMX_W_ADDR        12'hFE8
`define DMX_BANK_MASK     8'h0F
// ==========================================================
// phase codes
`define DMX_Q1            2'h0
`define DMX_Q2            2'h1
`define DMX_Q4            2'h3
// ==========================================================
// reset values
`define DMX_RST_BYTE      8'h00
`define DMX_RST_ADDR      12'h000
`endif

//--- verilog/dmx_phase_gen.v
/*
 four-phase sequencer: one instruction cycle per four core clocks.
 assumes a single core clock and active-high async reset.
*/
`timescale 1ns/1ps
`include "dmx_defs.vh"
module dmx_phase_gen (
    // clock and reset
    input  wire       core_clk,
    input  wire       sys_rst,
    // phase
    output reg  [1:0] phase_r
);
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_r <= `DMX_Q1;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end
endmodule

//--- verif/dmx_exec_checker.sv
/* assertions on the dmx_exec ports.
 assumes one instruction per 4 clocks, results written at q4. */
`timescale 1ns/1ps
`include "dmx_defs.vh"
module dmx_exec_checker (
    input wire        core_clk,
    input wire        sys_rst,
    input wire [15:0] instr,
    input wire        mem_rd_en_r,
    input wire        mem_wr_en_r,
    input wire [7:0]  work_r,
    input wire [7:0]  bank_select_register_r,
    input wire [7:0]  product_high_byte_r,
    input wire [7:0]  product_low_byte_r,
    input wire        copy_second_r
);
// ==========================================
// properties
default clocking @(posedge core_clk); endclocking
default disable iff (sys_rst);
bank_hi_a: assert property (bank_select_register_r[7:4] == 4'h0)
    else $error("bank upper nibble set");
bank_val_a: assert property ($changed(bank_select_register_r) |->
    $past(instr[15:8]) == `DMX_OP_BANK
    && bank_select_register_r == {4'h0, $past(instr[3:0])})
    else $error("bank load wrong");
work_lit_a: assert property ($past(instr[15:8]) == `DMX_OP_LIT_W
    && $changed(work_r) |-> work_r == $past(instr[7:0]))
    else $error("literal load wrong");
mul_val_a: assert property ($changed({product_high_byte_r,
    product_low_byte_r}) |-> {product_high_byte_r, product_low_byte_r}
    == $past(work_r) * $past(instr[7:0]))
    else $error("product wrong");
mul_keep_w_a: assert property (instr[15:8] == `DMX_OP_MUL
    |=> $stable(work_r)) else $error("multiply changed work");
// one strobe per instruction cycle at most
wr_once_a: assert property (mem_wr_en_r |=> !mem_wr_en_r [*3])
    else $error("write strobe repeated");
rd_once_a: assert property (mem_rd_en_r |=> !mem_rd_en_r [*3])
    else $error("read strobe repeated");
rd_first_a: assert property (mem_rd_en_r |-> !copy_second_r)
    else $error("read in second copy cycle");
cover property ($changed(product_low_byte_r));
cover property ($rose(copy_second_r));
cover property (mem_wr_en_r);
endmodule
bind dmx_exec dmx_exec_checker i_dmx_exec_checker (
    .core_clk(core_clk), .sys_rst(sys_rst), .instr(instr),
    .mem_rd_en_r(mem_rd_en_r), .mem_wr_en_r(mem_wr_en_r),
    .work_r(work_r), .bank_select_register_r(bank_select_register_r),
    .product_high_byte_r(product_high_byte_r),
    .product_low_byte_r(product_low_byte_r),
    .copy_second_r(copy_second_r));

//--- verif/tb_dmx_exec.sv
/* self-checking bench for dmx_exec.
 assumes q1 at the first edge after reset, one word per 4 clocks. */
`timescale 1ns/1ps
module tb_dmx_exec;
reg         core_clk = 1'b0;
reg         sys_rst = 1'b1;
reg  [15:0] instr = 16'h0000;
reg         ext_set_en = 1'b0;
wire [11:0] mem_addr_r;
wire [7:0]  mem_wdata_r, work_r, bank_select_register, ph, pl;
wire        rd, wr;
wire [1:0]  phase_seen;
wire [7:0]  mem_rdata = mem_addr_r[7:0] ^ 8'hA5;
reg  [11:0] wa = 12'h000;
reg  [7:0]  wd = 8'h00;
int         mismatches = 0;
int         n_compared = 0;
always #50 core_clk = ~core_clk;
always @(posedge core_clk) if (wr) begin
    wa <= mem_addr_r;
    wd <= mem_wdata_r;
end
dmx_exec i_dmx_exec (.core_clk(core_clk), .sys_rst(sys_rst),
    .instr(instr), .ext_set_en(ext_set_en), .index_base_hi(8'h00),
    .index_base(12'h200), .mem_rdata(mem_rdata),
    .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r),
    .mem_rd_en_r(rd), .mem_wr_en_r(wr), .work_r(work_r),
    .bank_select_register_r(bank_select_register), .product_high_byte_r(ph),
    .product_low_byte_r(pl), .phase_out_r(phase_seen), .copy_second_r());
// ==========================================
// shared tasks
task op(input [15:0] w);
    instr = w;
    repeat (4) @(negedge core_clk);
endtask
task chk(input string what, input [15:0] exp, input [15:0] got);
    n_compared++;
    if (got !== exp) begin
        mismatches++;
        $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
endtask
task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
// ==========================================
// scenarios
task t_mul;
    op(16'h0EC4);
    chk("work", 16'h00C4, {8'h00, work_r});
    chk("phase at q4", 16'h0003, {14'h0000, phase_seen});
    op(16'h0DFF);
    chk("prod", 16'h00C4 * 16'h00FF, {ph, pl});
    chk("work kept", 16'h00C4, {8'h00, work_r});
    op(16'h0D00);
    chk("zero prod", 16'h0000, {ph, pl});
    op(16'h0EFF);
    op(16'h0DFF);
    chk("max prod", 16'h00FF * 16'h00FF, {ph, pl});
    $display("test multiply done");
endtask
task t_store;
    op(16'h01A7);
    chk("bank", 16'h0007, {8'h00, bank_select_register});
    op(16'h6F34); op(0);
    chk("banked", 16'h0734, {4'h0, wa});
    chk("data", 16'h00FF, {8'h00, wd});
    op(16'h6E70); op(0);
    chk("access hi", 16'h0F70, {4'h0, wa});
    op(16'h6E5F); op(0);
    chk("access lo", 16'h005F, {4'h0, wa});
    ext_set_en = 1'b1;
    op(16'h6E10); op(0);
    chk("indexed", 16'h0210, {4'h0, wa});
    ext_set_en = 1'b0;
    $display("test store done");
endtask
task t_copy;
    // destination kept clear of pc-low and stack-top bytes
    op(16'hC123); op(16'hF5C3); op(0);
    chk("copy addr", 16'h05C3, {4'h0, wa});
    chk("copy data", {8'h00, 8'h23 ^ 8'hA5}, {8'h00, wd});
    op(16'hC0AB); op(16'hFFE8); op(0);
    chk("copy to w", {8'h00, 8'hAB ^ 8'hA5}, {8'h00, work_r});
    $display("test copy done");
endtask
initial begin
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    t_mul;
    t_store;
    t_copy;
    print_verdict;
end
initial begin
    #200000;
    mismatches++;
    print_verdict;
end
endmodule
